// ===== rtl/llrc_pkg.sv
// Package for the low latency core rate control register bank
package llrc_pkg;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam int ADDR_W = 16;
	localparam logic [15:0] OFS_RATE_CTRL = 16'h0009;
	localparam logic [15:0] OFS_STOP_CNT = 16'h000a;
	localparam logic [15:0] OFS_RUN_CTRL = 16'h0100;
	localparam logic [15:0] OFS_STATUS = 16'h0101;
	localparam logic [15:0] OFS_FAST_DIV = 16'h0102;
	localparam int RATIO_LSB = 3;
	localparam int RATE_LSB = 1;
	localparam int STOP_LSB = 0;
	localparam int RUN_BIT = 0;
	localparam logic [7:0] RST_RATE_CTRL = 8'h04;
	localparam logic [7:0] RST_STOP_CNT = 8'h00;
	localparam logic [7:0] RST_FAST_DIV = 8'h00;

	// Field codes
	localparam logic [1:0] RATIO_EQ = 2'h0;
	localparam logic [1:0] RATIO_DIV4 = 2'h1;
	localparam logic [1:0] RATIO_DIV8 = 2'h2;
	localparam logic [1:0] RATE_96K = 2'h1;
	localparam logic [1:0] RATE_192K = 2'h2;
	localparam logic [1:0] RATE_768K = 2'h3;
	localparam logic [4:0] STOP_NONE = 5'h00;
	localparam logic [4:0] STOP_RSVD = 5'h01;

	// Timing: master clock 250 MHz, core master clock 6.144 MHz
	localparam int CLK_KHZ = 250000;
	localparam int MCLK_HZ = 6144000;
	localparam int MCLK_CYC = (CLK_KHZ * 1000) / MCLK_HZ;
	localparam int K96_DIV = 64;
	localparam int K192_DIV = 32;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} llrc_bus_s;

	typedef struct packed {
		logic [1:0] ratio;
		logic [1:0] rate;
		logic [4:0] stop;
		logic [2:0] fast_div;
	} llrc_cfg_s;

endpackage

// ===== rtl/llrc_rate_gen.sv
// Fast and slow processing rate tick generator
`timescale 1ns/1ps
module llrc_rate_gen
	import llrc_pkg::*;
#(
	parameter int MCLK_CYCLES = MCLK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Applied settings
	input wire llrc_pkg::llrc_cfg_s cfg,
	input wire logic run,
	// Rate ticks
	output logic fast_tick,
	output logic slow_tick
);

	// ****************************************************************
	// Master clock enable
	// ****************************************************************
	logic [7:0] mclk_cnt_r;
	logic mclk_en;
	assign mclk_en = (mclk_cnt_r == 8'(MCLK_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (sys_rst || !run || mclk_en) begin
			mclk_cnt_r <= 8'h00;
		end else begin
			mclk_cnt_r <= mclk_cnt_r + 8'h01;
		end
	end

	// ****************************************************************
	// Fast rate divisor
	// ****************************************************************
	logic [6:0] fast_div;
	always_comb begin
		case (cfg.rate)
			RATE_96K: fast_div = 7'(K96_DIV);
			RATE_192K: fast_div = 7'(K192_DIV);
			RATE_768K: begin
				case (cfg.fast_div)
					3'h0: fast_div = 7'd8;
					3'h1: fast_div = 7'd9;
					3'h2: fast_div = 7'd10;
					3'h3: fast_div = 7'd12;
					3'h4: fast_div = 7'd14;
					default: fast_div = 7'd16;
				endcase
			end
			default: fast_div = 7'(K192_DIV);
		endcase
	end

	logic [6:0] fast_cnt_r;
	logic fast_hit;
	assign fast_hit = mclk_en && (fast_cnt_r == fast_div - 7'd1);

	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			fast_cnt_r <= 7'h00;
		end else if (fast_hit) begin
			fast_cnt_r <= 7'h00;
		end else if (mclk_en) begin
			fast_cnt_r <= fast_cnt_r + 7'h01;
		end
	end

	// ****************************************************************
	// Slow rate from fast rate
	// ****************************************************************
	logic [2:0] slow_cnt_r;
	logic [2:0] slow_last;
	always_comb begin
		case (cfg.ratio)
			RATIO_EQ: slow_last = 3'h0;
			RATIO_DIV4: slow_last = 3'h3;
			RATIO_DIV8: slow_last = 3'h7;
			default: slow_last = 3'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			slow_cnt_r <= 3'h0;
		end else if (fast_hit) begin
			slow_cnt_r <= (slow_cnt_r == slow_last) ? 3'h0 :
				slow_cnt_r + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fast_tick <= 1'b0;
			slow_tick <= 1'b0;
		end else begin
			fast_tick <= fast_hit;
			slow_tick <= fast_hit && (slow_cnt_r == slow_last);
		end
	end

endmodule

// ===== rtl/llrc_top.sv
// Low latency core rate control register bank
//
// Overview of operation
// - Bits 4:3 set slow rate: equal, quarter or eighth of fast rate
// - Bits 2:1 pick core rate: 96k, 192k, 768k; code 00 reserved
// - New field values apply only while the run flag is clear
// - Count n of two or more runs addresses zero to n minus two
// - Count zero runs all instructions; count one is reserved
// - At 768k code fast rate is master clock over programmable divisor
`timescale 1ns/1ps
module llrc_top
	import llrc_pkg::*;
#(
	parameter int PROG_DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire llrc_pkg::llrc_bus_s bus,
	output logic [7:0] rdata,
	// Core facing
	output llrc_pkg::llrc_cfg_s core_cfg,
	output logic core_run,
	output logic [4:0] last_addr,
	output logic run_all,
	output logic fast_tick,
	output logic slow_tick
);
	import llrc_pkg::*;

	// ****************************************************************
	// Software registers
	// ****************************************************************
	logic [7:0] rate_ctrl_r;
	logic [7:0] stop_cnt_r;
	logic [7:0] fast_div_r;
	logic run_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rate_ctrl_r <= RST_RATE_CTRL;
			stop_cnt_r <= RST_STOP_CNT;
			fast_div_r <= RST_FAST_DIV;
			run_r <= 1'b0;
		end else if (bus.wr) begin
			case (bus.addr)
				OFS_RATE_CTRL: rate_ctrl_r <= {3'h0, bus.wdata[4:0]};
				OFS_STOP_CNT: stop_cnt_r <= {3'h0, bus.wdata[4:0]};
				OFS_FAST_DIV: fast_div_r <= {5'h00, bus.wdata[2:0]};
				OFS_RUN_CTRL: run_r <= bus.wdata[RUN_BIT];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Applied settings, frozen while running
	// ****************************************************************
	llrc_cfg_s cfg_r;
	llrc_cfg_s cfg_nxt;
	always_comb begin
		cfg_nxt.ratio = rate_ctrl_r[RATIO_LSB +: 2];
		cfg_nxt.rate = rate_ctrl_r[RATE_LSB +: 2];
		cfg_nxt.stop = stop_cnt_r[STOP_LSB +: 5];
		cfg_nxt.fast_div = fast_div_r[2:0];
		// Reserved codes keep the previous applied value
		if (cfg_nxt.rate == 2'h0) begin
			cfg_nxt.rate = cfg_r.rate;
		end
		if (cfg_nxt.ratio == 2'h3) begin
			cfg_nxt.ratio = cfg_r.ratio;
		end
		if (cfg_nxt.stop == STOP_RSVD) begin
			cfg_nxt.stop = cfg_r.stop;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_r <= '{ratio: RATIO_EQ, rate: RATE_192K,
				stop: STOP_NONE, fast_div: 3'h0};
		end else if (!run_r) begin
			cfg_r <= cfg_nxt;
		end
	end

	// ****************************************************************
	// Program stop decode
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			last_addr <= 5'(PROG_DEPTH - 1);
			run_all <= 1'b1;
		end else if (cfg_r.stop == STOP_NONE) begin
			last_addr <= 5'(PROG_DEPTH - 1);
			run_all <= 1'b1;
		end else begin
			last_addr <= cfg_r.stop - 5'd2;
			run_all <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			core_cfg <= '0;
			core_run <= 1'b0;
		end else begin
			core_cfg <= cfg_r;
			core_run <= run_r;
		end
	end

	// ****************************************************************
	// Rate ticks
	// ****************************************************************
	llrc_rate_gen u_rate (
		.clk(clk),
		.sys_rst(sys_rst),
		.cfg(cfg_r),
		.run(run_r),
		.fast_tick(fast_tick),
		.slow_tick(slow_tick)
	);

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				OFS_RATE_CTRL: rdata <= rate_ctrl_r;
				OFS_STOP_CNT: rdata <= stop_cnt_r;
				OFS_FAST_DIV: rdata <= fast_div_r;
				OFS_RUN_CTRL: rdata <= {7'h00, run_r};
				OFS_STATUS: rdata <= {cfg_r.stop[2:0], cfg_r.ratio,
					cfg_r.rate, run_r};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule

// ===== sim/llrc_props.sv
// Assertions for the core rate control register bank
`timescale 1ns/1ps
module llrc_props
	import llrc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Core side
	input wire llrc_pkg::llrc_cfg_s core_cfg,
	input wire logic core_run,
	input wire logic [4:0] last_addr,
	input wire logic run_all,
	input wire logic fast_tick,
	input wire logic slow_tick
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Expected fast period in clock cycles
	logic [11:0] exp_per;
	always_comb begin
		case (core_cfg.rate)
			RATE_96K: exp_per = 12'(K96_DIV * MCLK_CYC);
			RATE_768K: begin
				case (core_cfg.fast_div)
					3'h0: exp_per = 12'(8 * MCLK_CYC);
					3'h1: exp_per = 12'(9 * MCLK_CYC);
					3'h2: exp_per = 12'(10 * MCLK_CYC);
					3'h3: exp_per = 12'(12 * MCLK_CYC);
					3'h4: exp_per = 12'(14 * MCLK_CYC);
					default: exp_per = 12'(16 * MCLK_CYC);
				endcase
			end
			default: exp_per = 12'(K192_DIV * MCLK_CYC);
		endcase
	end

	// Cycles since the last fast tick, only while running
	logic [11:0] gap_r;
	logic gap_ok_r;
	always_ff @(posedge clk) begin
		if (sys_rst || !core_run) begin
			gap_r <= 12'h000;
			gap_ok_r <= 1'b0;
		end else if (fast_tick) begin
			gap_r <= 12'h001;
			gap_ok_r <= 1'b1;
		end else if (gap_r != 12'hfff) begin
			gap_r <= gap_r + 12'h001;
		end
	end

	a_cfg_frozen_run: assert property (core_run && $past(core_run) &&
		$past(core_run, 2) |-> $stable(core_cfg))
		else $error("core settings moved while running");
	a_rate_legal: assert property (!$past(sys_rst) &&
		!$past(sys_rst, 2) |-> core_cfg.rate != 2'h0)
		else $error("reserved core rate applied");
	a_ratio_legal: assert property (core_cfg.ratio != 2'h3)
		else $error("undefined rate ratio applied");
	a_stop_legal: assert property (core_cfg.stop != STOP_RSVD)
		else $error("reserved stop count applied");
	a_all_run: assert property (core_cfg == $past(core_cfg) &&
		core_cfg == $past(core_cfg, 2) |-> run_all == (core_cfg.stop == 5'h00))
		else $error("run all flag wrong");
	a_stop_addr: assert property (core_cfg == $past(core_cfg) &&
		core_cfg == $past(core_cfg, 2) && !run_all |->
		last_addr == core_cfg.stop - 5'h02)
		else $error("last address wrong");
	a_slow_on_fast: assert property (slow_tick |-> fast_tick)
		else $error("slow tick without fast tick");
	a_ratio_equal: assert property (core_run &&
		core_cfg.ratio == RATIO_EQ |-> slow_tick == fast_tick)
		else $error("equal ratio ticks differ");
	a_fast_period: assert property (core_run && gap_ok_r |->
		fast_tick == (gap_r == exp_per))
		else $error("fast period wrong");
	cover property (slow_tick && core_cfg.ratio == RATIO_DIV4);
	cover property (core_run && fast_tick);
	cover property (!run_all && last_addr == 5'h1d);
endmodule
bind llrc_top llrc_props u_props (.clk(clk), .sys_rst(sys_rst),
	.core_cfg(core_cfg), .core_run(core_run), .last_addr(last_addr),
	.run_all(run_all), .fast_tick(fast_tick), .slow_tick(slow_tick));

// ===== sim/llrc_top_test.sv
// Self-checking testbench for the core rate control register bank
`timescale 1ns/1ps
module llrc_top_test;
	import llrc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	llrc_bus_s bus = '0;
	logic [7:0] rdata;
	llrc_cfg_s core_cfg;
	logic core_run, run_all, fast_tick, slow_tick;
	logic [4:0] last_addr;
	int fails = 0;
	int tests_run = 0;
	llrc_top dut_u (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
		.core_cfg(core_cfg), .core_run(core_run), .last_addr(last_addr),
		.run_all(run_all), .fast_tick(fast_tick), .slow_tick(slow_tick));
	initial begin
		forever #2 clk = ~clk;
	end
	// ****
	// Bus and compare tasks
	// ****
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk({4'h0, rdata}, {4'h0, e});
	endtask
	task automatic ck_rr(input logic [3:0] e);
		idle(3);
		chk({8'h0, core_cfg.ratio, core_cfg.rate}, {8'h0, e});
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_rates();
		for (int r = 0; r < 3; r++) begin
			for (int s = 1; s < 4; s++) begin
				wr(OFS_RATE_CTRL, {3'h0, 2'(r), 2'(s), 1'b0});
				ck_rr(4'(r * 4 + s));
			end
		end
		wr(OFS_RATE_CTRL, 8'h00);
		ck_rr(4'h3);
		wr(OFS_RATE_CTRL, 8'h1a);
		ck_rr(4'h1);
		rd(OFS_RATE_CTRL, 8'h1a);
		rd(16'h0003, 8'h00);
	endtask
	task automatic t_stop();
		logic [4:0] sv [5] = '{5'h07, 5'h02, 5'h1f, 5'h00, 5'h01};
		logic [5:0] ev [5] = '{6'h05, 6'h00, 6'h1d, 6'h3f, 6'h3f};
		for (int i = 0; i < 5; i++) begin
			wr(OFS_STOP_CNT, {3'h0, sv[i]});
			idle(3);
			chk({6'h0, run_all, last_addr}, {6'h0, ev[i]});
		end
	endtask
	task automatic t_run();
		int n;
		wr(OFS_RATE_CTRL, 8'h06);
		wr(OFS_STOP_CNT, 8'h07);
		wr(OFS_RUN_CTRL, 8'h01);
		for (n = 0; n < 600 && fast_tick !== 1'b1; n++) idle(1);
		chk({11'h0, fast_tick}, 12'h001);
		wr(OFS_RATE_CTRL, 8'h0a);
		wr(OFS_STOP_CNT, 8'h02);
		ck_rr(4'h3);
		chk({7'h0, last_addr}, 12'h005);
		wr(OFS_RUN_CTRL, 8'h00);
		ck_rr(4'h5);
		chk({7'h0, last_addr}, 12'h000);
		wr(OFS_RATE_CTRL, 8'h0e);
		wr(OFS_RUN_CTRL, 8'h01);
		idle(1500);
		wr(OFS_RUN_CTRL, 8'h00);
	endtask
	task automatic t_ticks();
		int nf;
		int ns;
		nf = 0;
		ns = 0;
		wr(OFS_FAST_DIV, 8'h05);
		wr(OFS_STOP_CNT, 8'h03);
		wr(OFS_RATE_CTRL, 8'h16);
		wr(OFS_RUN_CTRL, 8'h01);
		idle(2);
		chk({11'h0, core_run}, 12'h001);
		chk({4'h0, core_cfg.stop, core_cfg.fast_div}, 12'h01d);
		rd(OFS_FAST_DIV, 8'h05);
		rd(OFS_STATUS, 8'h77);
		repeat (8 * 640 + 100) begin
			idle(1);
			nf += fast_tick;
			ns += (slow_tick && fast_tick);
		end
		chk(12'(nf), 12'h008);
		chk(12'(ns), 12'h001);
		wr(OFS_RUN_CTRL, 8'h00);
		idle(2);
		chk({11'h0, core_run}, 12'h000);
	endtask
	task automatic close_out();
		$display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rd(OFS_RATE_CTRL, RST_RATE_CTRL);
		t_rates();
		t_stop();
		t_run();
		t_ticks();
		close_out();
	end
	initial begin
		#100000;
		fails++;
		close_out();
	end
endmodule
